/* File: sfr_pkg.sv */
// Package: register map, reset values and field layout for the register bank
package sfr_pkg;

  // Data-memory offsets within a bank (7-bit)
  localparam logic [6:0] OFS_INDIRECT   = 7'h00;
  localparam logic [6:0] OFS_TIMER0_COUNT       = 7'h01;
  localparam logic [6:0] OFS_PCL        = 7'h02;
  localparam logic [6:0] OFS_STATUS     = 7'h03;
  localparam logic [6:0] OFS_POINTER    = 7'h04;
  localparam logic [6:0] OFS_PORT_A     = 7'h05;
  localparam logic [6:0] OFS_PORT_B     = 7'h06;
  localparam logic [6:0] OFS_PORT_C     = 7'h07;
  localparam logic [6:0] OFS_PORT_D     = 7'h08;
  localparam logic [6:0] OFS_PORT_E     = 7'h09;
  localparam logic [6:0] OFS_PCH_BUF    = 7'h0a;
  localparam logic [6:0] OFS_INT_CTRL   = 7'h0b;
  localparam logic [6:0] OFS_PFLAGS_1   = 7'h0c;
  localparam logic [6:0] OFS_PFLAGS_2   = 7'h0d;
  localparam logic [6:0] OFS_TMR1_LO    = 7'h0e;
  localparam logic [6:0] OFS_TMR1_HI    = 7'h0f;
  localparam logic [6:0] OFS_SER_TX     = 7'h19;
  localparam logic [6:0] OFS_SER_RX     = 7'h1a;
  localparam logic [6:0] OFS_CC2_LO     = 7'h1b;
  localparam logic [6:0] OFS_CC2_HI     = 7'h1c;
  localparam logic [6:0] OFS_CC2_CTRL   = 7'h1d;
  localparam logic [6:0] OFS_CONV_RES   = 7'h1e;
  localparam logic [6:0] OFS_CONV_CTRL0 = 7'h1f;
  localparam logic [6:0] OFS_BAUD       = 7'h19;
  localparam logic [6:0] OFS_CONV_CTRL1 = 7'h1f;
  localparam logic [6:0] OFS_GPR_FIRST  = 7'h20;
  localparam logic [6:0] OFS_GPR_LAST   = 7'h7f;
  localparam int         GPR_WORDS      = 96;

  // AXI byte addresses: data-memory address times four
  localparam logic [11:0] AXI_MEM_LAST  = 12'h3fc;
  // Own control/status block above the data-memory window
  localparam logic [11:0] AXI_CTRL      = 12'h400;
  localparam logic [11:0] AXI_IRQ_STAT  = 12'h404;
  localparam logic [11:0] AXI_IRQ_MASK  = 12'h408;
  localparam logic [11:0] AXI_PC        = 12'h40c;
  localparam logic [11:0] AXI_ID        = 12'h410;

  // Control register fields
  localparam int CTRL_HAS_PORTS_DE = 0;
  localparam int CTRL_HAS_CONV     = 1;
  localparam int CTRL_PC_LOAD      = 2;
  localparam logic [7:0] CTRL_RST  = 8'h03;

  // Interrupt status fields
  localparam int IRQ_PC_LOAD   = 0;
  localparam int IRQ_INDIRECT  = 1;
  localparam int IRQ_UNMAPPED  = 2;
  localparam int IRQ_BITS      = 3;

  // Reset values: power-on/brown-out, then other resets
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] PCH_MASK        = 8'h1f;
  localparam logic [7:0] STATUS_POR      = 8'h18;
  localparam logic [7:0] STATUS_OTHER_KEEP = 8'h07;
  localparam logic [7:0] PORT_A_MASK     = 8'h3f;
  localparam logic [7:0] PORT_E_MASK     = 8'h07;
  localparam logic [7:0] PFLAGS2_MASK    = 8'h01;
  localparam logic [7:0] INT_CTRL_KEEP   = 8'h01;
  localparam logic [7:0] CONV0_MASK      = 8'hfd;
  localparam logic [7:0] STATUS_RSVD     = 8'h3f;

  // Arbitrary identity value
  localparam logic [31:0] BLOCK_ID       = 32'h0000_5a01;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sfr_pkg

/* File: sfr_reset_class.sv */
// Reset class tracker: power-on/brown-out versus other resets
`timescale 1ns/1ps
module sfr_reset_class (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic brown_out_reset,
  input  wire logic master_clear_input,
  input  wire logic watchdog_reset,
  output logic      reset_active,
  output logic      reset_is_power_up
);
  typedef struct packed {
    logic [2:0] bor_sync;
    logic       seen_power;
    logic       pwr_class;
  } sfr_rc_s;

  sfr_rc_s cur_ff;
  sfr_rc_s nxt_cur;
  logic    bor_seen;

  // Pin input: counts only while stages two and three are both high
  assign bor_seen = cur_ff.bor_sync[1] & cur_ff.bor_sync[2];

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.bor_sync = {cur_ff.bor_sync[1:0], brown_out_reset};
    nxt_cur.seen_power = 1'b1;
    if (bor_seen)
    begin
      nxt_cur.pwr_class = 1'b1;
    end
    else if (master_clear_input | watchdog_reset)
    begin
      nxt_cur.pwr_class = 1'b0;
    end
    else if (cur_ff.seen_power)
    begin
      nxt_cur.pwr_class = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_ff.bor_sync   <= 3'b000;
      cur_ff.seen_power <= 1'b0;
      // Bus reset doubles as power-up; there is no separate power-on pin
      cur_ff.pwr_class  <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign reset_active      = ~aresetn | bor_seen | master_clear_input | watchdog_reset;
  assign reset_is_power_up = ~aresetn | cur_ff.pwr_class | bor_seen;
endmodule : sfr_reset_class

/* File: sfr_register_bank.sv */
// Data-memory register bank with AXI4-Lite access
// Summary of operation
// - Unimplemented addresses in either bank read zero and ignore writes.
// - Special function registers other than indirect are storage cells shared by core and peripherals; port, receive and converter-result reads return inputs.
// - Missing ports D/E or converter registers read zero on variants lacking them.
// - The indirect location has no storage and acts on the cell the pointer addresses.
// - Registers take one value on power-on/brown-out and possibly another on other resets.
// - Core registers appear at the same offset in both banks.
// - Master clear and watchdog resets select the other-reset values.
// - The upper PC byte is not directly accessible; the buffer loads PC bits 12:8.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module sfr_register_bank (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        brown_out_reset,
  input  wire logic        master_clear_input,
  input  wire logic        watchdog_reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic [7:0]  port_d_pins,
  input  wire logic [7:0]  port_e_pins,
  input  wire logic [7:0]  serial_receive_in,
  input  wire logic [7:0]  converter_result_in,
  output logic [7:0]       port_a_latch,
  output logic [7:0]       port_b_latch,
  output logic [7:0]       port_c_latch,
  output logic [7:0]       port_d_latch,
  output logic [7:0]       port_e_latch,
  output logic [12:0]      program_counter,
  output logic             irq
);
  localparam int IRQ_BITS_W = sfr_pkg::IRQ_BITS;

  typedef struct packed {
    logic [2:0][7:0] pins_a;
    logic [2:0][7:0] pins_b;
    logic [2:0][7:0] pins_c;
    logic [2:0][7:0] pins_d;
    logic [2:0][7:0] pins_e;
    logic [7:0]  timer0_count;
    logic [7:0]  program_counter_low;
    logic [4:0]  pc_hi;
    logic [7:0]  status;
    logic [7:0]  pointer;
    logic [7:0]  lat_a;
    logic [7:0]  lat_b;
    logic [7:0]  lat_c;
    logic [7:0]  lat_d;
    logic [7:0]  lat_e;
    logic [7:0]  pch_buf;
    logic [7:0]  int_ctrl;
    logic [7:0]  pflags1;
    logic [7:0]  pflags2;
    logic [7:0]  tmr1_lo;
    logic [7:0]  tmr1_hi;
    logic [7:0]  ser_tx;
    logic [7:0]  cc2_lo;
    logic [7:0]  cc2_hi;
    logic [7:0]  cc2_ctrl;
    logic [7:0]  conv0;
    logic [7:0]  baud;
    logic [7:0]  conv1;
    logic [7:0]  ctrl;
    logic [IRQ_BITS_W-1:0] irq_stat;
    logic [IRQ_BITS_W-1:0] irq_mask;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sfr_st_s;

  sfr_st_s    cur_ff;
  sfr_st_s    nxt_cur;
  logic [7:0] gpr_ram [2*sfr_pkg::GPR_WORDS];
  logic       rst_act;
  logic       rst_pwr;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_mem;
  logic [7:0] wr_byte;
  logic [7:0] wr_dmem;
  logic [7:0] rd_dmem;
  logic [7:0] rd_byte;
  logic [7:0] gpr_rdq;
  logic       rd_gpr;
  logic       wr_gpr;
  logic [7:0] ram_idx_w;
  logic [7:0] ram_idx_r;
  logic       wr_mapped;
  logic       wr_indirect;
  logic       rd_mapped;

  sfr_reset_class u_reset_class (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .brown_out_reset    (brown_out_reset),
    .master_clear_input (master_clear_input),
    .watchdog_reset     (watchdog_reset),
    .reset_active       (rst_act),
    .reset_is_power_up  (rst_pwr)
  );

  // Read mux for one data-memory address; returns mapped flag in bit 8
  function automatic logic [8:0] sfr_read(input sfr_st_s s, input logic [7:0] a);
    logic [6:0] o;
    logic       b1;
    logic       de;
    logic       cv;
    o  = a[6:0];
    b1 = a[7];
    de = s.ctrl[sfr_pkg::CTRL_HAS_PORTS_DE];
    cv = s.ctrl[sfr_pkg::CTRL_HAS_CONV];
    sfr_read = {1'b0, sfr_pkg::RST_ZERO};
    unique case (o)
      sfr_pkg::OFS_INDIRECT: sfr_read = {1'b1, sfr_pkg::RST_ZERO};
      sfr_pkg::OFS_PCL:      sfr_read = {1'b1, s.program_counter_low};
      sfr_pkg::OFS_STATUS:   sfr_read = {1'b1, s.status};
      sfr_pkg::OFS_POINTER:  sfr_read = {1'b1, s.pointer};
      sfr_pkg::OFS_PCH_BUF:  sfr_read = {1'b1, s.pch_buf & sfr_pkg::PCH_MASK};
      sfr_pkg::OFS_INT_CTRL: sfr_read = {1'b1, s.int_ctrl};
      default:
      begin
        if (!b1)
        begin
          unique case (o)
            sfr_pkg::OFS_TIMER0_COUNT:     sfr_read = {1'b1, s.timer0_count};
            sfr_pkg::OFS_PORT_A:   sfr_read = {1'b1, s.pins_a[2] & sfr_pkg::PORT_A_MASK};
            sfr_pkg::OFS_PORT_B:   sfr_read = {1'b1, s.pins_b[2]};
            sfr_pkg::OFS_PORT_C:   sfr_read = {1'b1, s.pins_c[2]};
            sfr_pkg::OFS_PORT_D:   sfr_read = {1'b1, de ? s.pins_d[2] : sfr_pkg::RST_ZERO};
            sfr_pkg::OFS_PORT_E:   sfr_read = {1'b1, de ? (s.pins_e[2] & sfr_pkg::PORT_E_MASK)
                                                        : sfr_pkg::RST_ZERO};
            sfr_pkg::OFS_PFLAGS_1: sfr_read = {1'b1, s.pflags1};
            sfr_pkg::OFS_PFLAGS_2: sfr_read = {1'b1, s.pflags2 & sfr_pkg::PFLAGS2_MASK};
            sfr_pkg::OFS_TMR1_LO:  sfr_read = {1'b1, s.tmr1_lo};
            sfr_pkg::OFS_TMR1_HI:  sfr_read = {1'b1, s.tmr1_hi};
            sfr_pkg::OFS_SER_TX:   sfr_read = {1'b1, s.ser_tx};
            sfr_pkg::OFS_SER_RX:   sfr_read = {1'b1, serial_receive_in};
            sfr_pkg::OFS_CC2_LO:   sfr_read = {1'b1, s.cc2_lo};
            sfr_pkg::OFS_CC2_HI:   sfr_read = {1'b1, s.cc2_hi};
            sfr_pkg::OFS_CC2_CTRL: sfr_read = {1'b1, s.cc2_ctrl};
            sfr_pkg::OFS_CONV_RES: sfr_read = {1'b1, cv ? converter_result_in : sfr_pkg::RST_ZERO};
            sfr_pkg::OFS_CONV_CTRL0: sfr_read = {1'b1, cv ? (s.conv0 & sfr_pkg::CONV0_MASK)
                                                          : sfr_pkg::RST_ZERO};
            default:               sfr_read = {1'b0, sfr_pkg::RST_ZERO};
          endcase
        end
        else
        begin
          unique case (o)
            sfr_pkg::OFS_BAUD:       sfr_read = {1'b1, s.baud};
            sfr_pkg::OFS_CONV_CTRL1: sfr_read = {1'b1, cv ? s.conv1 : sfr_pkg::RST_ZERO};
            default:                 sfr_read = {1'b0, sfr_pkg::RST_ZERO};
          endcase
        end
      end
    endcase
    if (o >= sfr_pkg::OFS_GPR_FIRST)
    begin
      sfr_read = {1'b1, gpr_rdq};
    end
  endfunction : sfr_read

  assign wr_fire = cur_ff.aw_held & cur_ff.w_held & ~cur_ff.bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_mem  = cur_ff.aw_addr <= sfr_pkg::AXI_MEM_LAST;
  assign wr_byte = cur_ff.w_data[7:0];

  assign wr_indirect = cur_ff.aw_addr[8:2] == sfr_pkg::OFS_INDIRECT;
  assign wr_dmem     = wr_indirect ? cur_ff.pointer : cur_ff.aw_addr[9:2];
  assign rd_dmem     = (s_axi_araddr[8:2] == sfr_pkg::OFS_INDIRECT) ? cur_ff.pointer
                                                                    : s_axi_araddr[9:2];
  assign wr_gpr    = wr_fire & wr_mem & cur_ff.w_strb[0] & (wr_dmem[6:0] >= sfr_pkg::OFS_GPR_FIRST);
  assign rd_gpr    = rd_dmem[6:0] >= sfr_pkg::OFS_GPR_FIRST;
  assign ram_idx_w = {wr_dmem[7], wr_dmem[6:0] - sfr_pkg::OFS_GPR_FIRST};
  assign ram_idx_r = {rd_dmem[7], rd_dmem[6:0] - sfr_pkg::OFS_GPR_FIRST};
  // Bank 1 RAM sits directly above the 96 bank 0 bytes
  assign gpr_rdq   = rd_gpr ? gpr_ram[ram_idx_r[7] ? ram_idx_r - 8'h20 : ram_idx_r]
                            : sfr_pkg::RST_ZERO;

  always_ff @(posedge aclk)
  begin
    if (wr_gpr)
    begin
      gpr_ram[ram_idx_w[7] ? ram_idx_w - 8'h20 : ram_idx_w] <= wr_byte;
    end
  end

  always_comb
  begin
    logic [8:0] rv;
    logic [8:0] wv;
    logic [6:0] wo;
    rv = sfr_read(cur_ff, rd_dmem);
    wv = sfr_read(cur_ff, wr_dmem);
    wo = wr_dmem[6:0];
    rd_mapped = rv[8];
    rd_byte   = rv[7:0];
    wr_mapped = wv[8];
    nxt_cur = cur_ff;
    nxt_cur.pins_a = {cur_ff.pins_a[1:0], port_a_pins};
    nxt_cur.pins_b = {cur_ff.pins_b[1:0], port_b_pins};
    nxt_cur.pins_c = {cur_ff.pins_c[1:0], port_c_pins};
    nxt_cur.pins_d = {cur_ff.pins_d[1:0], port_d_pins};
    nxt_cur.pins_e = {cur_ff.pins_e[1:0], port_e_pins};
    nxt_cur.ctrl[sfr_pkg::CTRL_PC_LOAD] = 1'b0;

    // AXI write address/data capture in either order
    if (s_axi_awvalid & s_axi_awready)
    begin
      nxt_cur.aw_held = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      nxt_cur.w_held = 1'b1;
      nxt_cur.w_data = s_axi_wdata;
      nxt_cur.w_strb = s_axi_wstrb;
    end

    if (wr_fire)
    begin
      nxt_cur.aw_held = 1'b0;
      nxt_cur.w_held  = 1'b0;
      nxt_cur.bvalid  = 1'b1;
      if (wr_mem)
      begin
        if (cur_ff.w_strb[0])
        begin
          unique case (wo)
            sfr_pkg::OFS_PCL:
            begin
              nxt_cur.program_counter_low   = wr_byte;
              nxt_cur.pc_hi = cur_ff.pch_buf[4:0];
              nxt_cur.irq_stat[sfr_pkg::IRQ_PC_LOAD] = 1'b1;
            end
            sfr_pkg::OFS_STATUS:  nxt_cur.status  = wr_byte & sfr_pkg::STATUS_RSVD;
            sfr_pkg::OFS_POINTER: nxt_cur.pointer = wr_byte;
            sfr_pkg::OFS_PCH_BUF: nxt_cur.pch_buf = wr_byte & sfr_pkg::PCH_MASK;
            sfr_pkg::OFS_INT_CTRL: nxt_cur.int_ctrl = wr_byte;
            default:
            begin
              if (!wr_dmem[7])
              begin
                unique case (wo)
                  sfr_pkg::OFS_TIMER0_COUNT:       nxt_cur.timer0_count     = wr_byte;
                  sfr_pkg::OFS_PORT_A:     nxt_cur.lat_a    = wr_byte & sfr_pkg::PORT_A_MASK;
                  sfr_pkg::OFS_PORT_B:     nxt_cur.lat_b    = wr_byte;
                  sfr_pkg::OFS_PORT_C:     nxt_cur.lat_c    = wr_byte;
                  sfr_pkg::OFS_PORT_D:     nxt_cur.lat_d    = wr_byte;
                  sfr_pkg::OFS_PORT_E:     nxt_cur.lat_e    = wr_byte & sfr_pkg::PORT_E_MASK;
                  sfr_pkg::OFS_PFLAGS_1:   nxt_cur.pflags1  = wr_byte;
                  sfr_pkg::OFS_PFLAGS_2:   nxt_cur.pflags2  = wr_byte & sfr_pkg::PFLAGS2_MASK;
                  sfr_pkg::OFS_TMR1_LO:    nxt_cur.tmr1_lo  = wr_byte;
                  sfr_pkg::OFS_TMR1_HI:    nxt_cur.tmr1_hi  = wr_byte;
                  sfr_pkg::OFS_SER_TX:     nxt_cur.ser_tx   = wr_byte;
                  sfr_pkg::OFS_CC2_LO:     nxt_cur.cc2_lo   = wr_byte;
                  sfr_pkg::OFS_CC2_HI:     nxt_cur.cc2_hi   = wr_byte;
                  sfr_pkg::OFS_CC2_CTRL:   nxt_cur.cc2_ctrl = wr_byte;
                  sfr_pkg::OFS_CONV_CTRL0: nxt_cur.conv0    = wr_byte & sfr_pkg::CONV0_MASK;
                  default: ;
                endcase
              end
              else
              begin
                unique case (wo)
                  sfr_pkg::OFS_BAUD:       nxt_cur.baud  = wr_byte;
                  sfr_pkg::OFS_CONV_CTRL1: nxt_cur.conv1 = wr_byte;
                  default: ;
                endcase
              end
            end
          endcase
          if (wr_indirect)
          begin
            nxt_cur.irq_stat[sfr_pkg::IRQ_INDIRECT] = 1'b1;
          end
        end
        if (!wr_mapped)
        begin
          nxt_cur.irq_stat[sfr_pkg::IRQ_UNMAPPED] = 1'b1;
        end
        nxt_cur.bresp = sfr_pkg::RESP_OKAY;
      end
      else
      begin
        nxt_cur.bresp = sfr_pkg::RESP_OKAY;
        unique case (cur_ff.aw_addr)
          sfr_pkg::AXI_CTRL:     nxt_cur.ctrl = wr_byte;
          // Write one to clear; a same-cycle set is applied after
          sfr_pkg::AXI_IRQ_STAT: nxt_cur.irq_stat = nxt_cur.irq_stat & ~wr_byte[IRQ_BITS_W-1:0]
                                                  | (nxt_cur.irq_stat & ~cur_ff.irq_stat);
          sfr_pkg::AXI_IRQ_MASK: nxt_cur.irq_mask = wr_byte[IRQ_BITS_W-1:0];
          sfr_pkg::AXI_PC, sfr_pkg::AXI_ID: nxt_cur.bresp = sfr_pkg::RESP_OKAY;
          default:               nxt_cur.bresp = sfr_pkg::RESP_SLVERR;
        endcase
      end
    end
    if (cur_ff.bvalid & s_axi_bready)
    begin
      nxt_cur.bvalid = 1'b0;
    end

    if (rd_fire)
    begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp  = sfr_pkg::RESP_OKAY;
      if (s_axi_araddr <= sfr_pkg::AXI_MEM_LAST)
      begin
        nxt_cur.rdata = {24'h000000, rd_mapped ? rd_byte : sfr_pkg::RST_ZERO};
      end
      else
      begin
        unique case (s_axi_araddr)
          sfr_pkg::AXI_CTRL:     nxt_cur.rdata = {24'h000000, cur_ff.ctrl};
          sfr_pkg::AXI_IRQ_STAT: nxt_cur.rdata = {29'h0, cur_ff.irq_stat};
          sfr_pkg::AXI_IRQ_MASK: nxt_cur.rdata = {29'h0, cur_ff.irq_mask};
          sfr_pkg::AXI_PC:       nxt_cur.rdata = {19'h0, cur_ff.pc_hi, cur_ff.program_counter_low};
          sfr_pkg::AXI_ID:       nxt_cur.rdata = sfr_pkg::BLOCK_ID;
          default:
          begin
            nxt_cur.rdata = 32'h0;
            nxt_cur.rresp = sfr_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    else if (cur_ff.rvalid & s_axi_rready)
    begin
      nxt_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst_act)
    begin
      cur_ff.status   <= rst_pwr ? sfr_pkg::STATUS_POR
                                 : (cur_ff.status & sfr_pkg::STATUS_OTHER_KEEP);
      cur_ff.int_ctrl <= rst_pwr ? sfr_pkg::RST_ZERO : (cur_ff.int_ctrl & sfr_pkg::INT_CTRL_KEEP);
      cur_ff.lat_a    <= rst_pwr ? sfr_pkg::RST_ZERO : cur_ff.lat_a;
      cur_ff.program_counter_low      <= sfr_pkg::RST_ZERO;
      cur_ff.pc_hi    <= 5'h00;
      cur_ff.pch_buf  <= sfr_pkg::RST_ZERO;
      cur_ff.pflags1  <= sfr_pkg::RST_ZERO;
      cur_ff.pflags2  <= sfr_pkg::RST_ZERO;
      cur_ff.ser_tx   <= sfr_pkg::RST_ZERO;
      cur_ff.cc2_ctrl <= sfr_pkg::RST_ZERO;
      cur_ff.conv0    <= sfr_pkg::RST_ZERO;
      cur_ff.ctrl     <= sfr_pkg::CTRL_RST;
      cur_ff.irq_stat <= '0;
      cur_ff.irq_mask <= '0;
      cur_ff.aw_held  <= 1'b0;
      cur_ff.w_held   <= 1'b0;
      cur_ff.bvalid   <= 1'b0;
      cur_ff.bresp    <= sfr_pkg::RESP_OKAY;
      cur_ff.rvalid   <= 1'b0;
      cur_ff.rdata    <= 32'h0;
      cur_ff.rresp    <= sfr_pkg::RESP_OKAY;
      cur_ff.pins_a   <= '0;
      cur_ff.pins_b   <= '0;
      cur_ff.pins_c   <= '0;
      cur_ff.pins_d   <= '0;
      cur_ff.pins_e   <= '0;
      // Unknown-or-unchanged registers hold, except timer0_count and pointer (clear on power-up) and the write capture (clears)
      cur_ff.timer0_count     <= rst_pwr ? sfr_pkg::RST_ZERO : cur_ff.timer0_count;
      cur_ff.pointer  <= rst_pwr ? sfr_pkg::RST_ZERO : cur_ff.pointer;
      cur_ff.lat_b    <= cur_ff.lat_b;
      cur_ff.lat_c    <= cur_ff.lat_c;
      cur_ff.lat_d    <= cur_ff.lat_d;
      cur_ff.lat_e    <= cur_ff.lat_e;
      cur_ff.tmr1_lo  <= cur_ff.tmr1_lo;
      cur_ff.tmr1_hi  <= cur_ff.tmr1_hi;
      cur_ff.cc2_lo   <= cur_ff.cc2_lo;
      cur_ff.cc2_hi   <= cur_ff.cc2_hi;
      cur_ff.baud     <= cur_ff.baud;
      cur_ff.conv1    <= cur_ff.conv1;
      cur_ff.aw_addr  <= 12'h000;
      cur_ff.w_data   <= 32'h0;
      cur_ff.w_strb   <= 4'h0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  // Refuse requests during every reset class, not only the bus reset
  assign s_axi_awready = ~cur_ff.aw_held & ~cur_ff.bvalid & ~rst_act;
  assign s_axi_wready  = ~cur_ff.w_held & ~cur_ff.bvalid & ~rst_act;
  assign s_axi_arready = ~cur_ff.rvalid & ~rst_act;
  assign s_axi_bvalid  = cur_ff.bvalid;
  assign s_axi_bresp   = cur_ff.bresp;
  assign s_axi_rvalid  = cur_ff.rvalid;
  assign s_axi_rdata   = cur_ff.rdata;
  assign s_axi_rresp   = cur_ff.rresp;
  assign port_a_latch  = cur_ff.lat_a;
  assign port_b_latch  = cur_ff.lat_b;
  assign port_c_latch  = cur_ff.lat_c;
  assign port_d_latch  = cur_ff.ctrl[sfr_pkg::CTRL_HAS_PORTS_DE] ? cur_ff.lat_d : 8'h00;
  assign port_e_latch  = cur_ff.ctrl[sfr_pkg::CTRL_HAS_PORTS_DE] ? cur_ff.lat_e : 8'h00;
  assign program_counter = {cur_ff.pc_hi, cur_ff.program_counter_low};
  assign irq = |(cur_ff.irq_stat & cur_ff.irq_mask);
endmodule : sfr_register_bank

/* File: sfr_monitor.sv */
// Bus timing and decode checker for the register bank
`timescale 1ns/1ps
module sfr_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [11:0] rd_q;
  always_ff @(posedge aclk) if (s_axi_arvalid && s_axi_arready) rd_q <= s_axi_araddr;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while held");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_UNMAP_ZERO: assert property (s_axi_rvalid && rd_q inside {[12'h268:12'h278]} |->
    s_axi_rdata == 32'h0 && s_axi_rresp == sfr_pkg::RESP_OKAY) else $error("hole not zero");
  AST_PCH_TOP: assert property (s_axi_rvalid && rd_q[11:2] inside {10'h0a, 10'h8a} |->
    s_axi_rdata[7:5] == 3'h0) else $error("pc buffer top bits set");
  AST_ABOVE_ERR: assert property (s_axi_rvalid && rd_q > 12'h410 |->
    s_axi_rresp == sfr_pkg::RESP_SLVERR) else $error("no error above window");
endmodule : sfr_monitor
bind sfr_register_bank sfr_monitor mon (.*);

/* File: sfr_pin_model.sv */
// Static pin and peripheral data levels seen by the bank
`timescale 1ns/1ps
module sfr_pin_model (
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_c_pins,
  output logic [7:0] port_d_pins,
  output logic [7:0] port_e_pins,
  output logic [7:0] serial_receive_in,
  output logic [7:0] converter_result_in
);
  // Held still so the three-stage pin sync has settled
  assign {port_a_pins, port_b_pins, port_c_pins, port_d_pins} = 32'h15c36996;
  assign {port_e_pins, serial_receive_in, converter_result_in} = 24'h05a73c;
endmodule : sfr_pin_model

/* File: special_function_register_map_tb_top.sv */
// Register-level tests of the bank over its bus
`timescale 1ns/1ps
module special_function_register_map_tb_top;
  logic aclk = 0, aresetn = 0, brown_out_reset = 0, master_clear_input = 0, watchdog_reset = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic [7:0] port_a_pins, port_b_pins, port_c_pins, port_d_pins, port_e_pins;
  logic [7:0] serial_receive_in, converter_result_in, port_a_latch, port_b_latch;
  logic [7:0] port_c_latch, port_d_latch, port_e_latch;
  logic [12:0] program_counter;
  int errors = 0, n_compared = 0;
  sfr_register_bank DUT (.*);
  sfr_pin_model pins (.*);
  initial forever #5 aclk = ~aclk;
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rb = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rv, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", e, rv);
  endtask : rc
  task automatic hit(input logic [2:0] v);
    @(posedge aclk);
    {brown_out_reset, master_clear_input, watchdog_reset} <= v;
    repeat (5) @(posedge aclk);
    {brown_out_reset, master_clear_input, watchdog_reset} <= 3'b000;
    repeat (6) @(posedge aclk);
  endtask : hit
  task automatic ic(input logic e);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : ic
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h028, 32'h0);
    hit(3'b100); rc(12'h00c, 32'h18);
    wr(12'h02c, 8'h81); hit(3'b010); rc(12'h02c, 32'h01);
    wr(12'h02c, 8'h80); hit(3'b001); rc(12'h22c, 32'h00);
    wr(12'h010, 8'h25); rc(12'h210, 32'h25);
    wr(12'h228, 8'hff); rc(12'h028, 32'h1f);
    wr(12'h008, 8'h34); ic(1'b0); chk("pc", 32'h1f34, {19'h0, program_counter});
    rc(12'h40c, 32'h1f34); rc(12'h410, sfr_pkg::BLOCK_ID);
    wr(12'h000, 8'h5a); rc(12'h094, 32'h5a); rc(12'h200, 32'h5a);
    wr(12'h010, 8'h00); rc(12'h000, 32'h0);
    wr(12'h3fc, 8'h77); rc(12'h3fc, 32'h77); wr(12'h280, 8'h11); rc(12'h280, 32'h11);
    wr(12'h018, 8'ha5); chk("latch", 32'ha5, {24'h0, port_b_latch}); rc(12'h018, 32'hc3);
    wr(12'h014, 8'hff); chk("latch", 32'h3f, {24'h0, port_a_latch});
    wr(12'h01c, 8'h3a); chk("latch", 32'h3a, {24'h0, port_c_latch});
    wr(12'h038, 8'h4e); rc(12'h038, 32'h4e);
    wr(12'h268, 8'hff); rc(12'h268, 32'h0); rd(12'h420); chk("rresp", 32'h2, {30'h0, rr});
    wr(12'h420, 8'h01); chk("bresp", 32'h2, {30'h0, rb});
    wr(12'h268, 8'h00); chk("bresp", 32'h0, {30'h0, rb});
    wr(12'h020, 8'h5c); chk("latch", 32'h5c, {24'h0, port_d_latch});
    wr(12'h024, 8'hff); chk("latch", 32'h07, {24'h0, port_e_latch});
    rc(12'h078, 32'h3c); rc(12'h020, 32'h96); wr(12'h400, 8'h00);
    rc(12'h078, 32'h0); rc(12'h020, 32'h0);
    chk("latch", 32'h0, {16'h0, port_d_latch, port_e_latch});
    wr(12'h408, 8'h00); ic(1'b0); rc(12'h404, 32'h7); wr(12'h408, 8'h04); ic(1'b1);
    wr(12'h404, 8'h07); ic(1'b0); rc(12'h404, 32'h0);
    stop_test();
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    errors++;
    stop_test();
  end
endmodule : special_function_register_map_tb_top
